// ==== core/ref_clock_quality_monitor.sv ====
`timescale 1ns/1ps
`include "ref_mon_defines.svh"
// Behaviour
// - input eleven default priority 12 when strapped primary, 1 when secondary
// - channels 1101 and 1110 default to priorities 14 and 15
// - input mode bit 2 picks SONET or SDH rate set
// - composite clock decoders flag loss after 1 ms idle or low amplitude
// - frequency check runs only while input shows no irregularity or loss
// - loss of activity or out-of-band marks the input unavailable
// - fast detector on locked input flags two missing cycles, forces holdover
// - fast flag is status bit 6; phase-lost mode bit swaps its meaning
// - recovery before alarms resumes tracking with nearest-edge locking
// - one bucket per input, each picks one of four configurations
// - bucket gains one per 128 ms period holding an irregularity
// - bucket saturates at programmed size, fill rate 8 per second
// - leak runs at full, half, quarter or eighth of fill rate
// - fill and leak due together: fill only
// - alarm set at set threshold, cleared once decayed to clear threshold
// - non-selected fails on inactivity or band; selected also phase, freq, range
// - selected input lost: switch to best qualified priority
// - activity invalidation of selected input raises a status event
// - monitor cfg bit 6 drives raw fast-loss status onto test data out
// - set threshold 6 on a dead input alarms after 0.75 s
// - clear time is 2^decay times size minus clear threshold over 8 s
// - frequency config bits 5:4 pick the bucket configuration
module ref_clock_quality_monitor #(
    parameter int NUM_REFS = 14,
    parameter int GAP_W = 20,
    parameter int PERIOD_CYC = `MON_PERIOD_MS * `CLK_KHZ,
    parameter int AMI_LOS_CYC = `AMI_LOS_US * `CLK_KHZ / 1000
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic [NUM_REFS-1:0] I_REF_IN,
    input wire logic [1:0] I_AMI_LOW_AMP,
    input wire logic I_PRIMARY_SECONDARY_STRAP,
    input wire logic I_NETWORK_STANDARD_PIN,
    input wire logic [NUM_REFS-1:0] I_OUT_OF_BAND,
    input wire logic I_SEL_PHASE_FAULT,
    input wire logic I_SEL_FREQ_FAULT,
    input wire logic I_SEL_OUT_OF_RANGE,
    input wire logic I_PHASE_LOST,
    input wire logic I_JTAG_TDO,
    input wire logic [11:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [11:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [NUM_REFS-1:0] O_REF_AVAILABLE,
    output logic [NUM_REFS-1:0] O_FREQ_CHECK_EN,
    output logic [NUM_REFS-1:0] O_ACT_ALARM,
    output logic [1:0] O_AMI_LOS,
    output logic [3:0] O_SELECTED,
    output logic O_DPLL_HOLDOVER,
    output logic O_RELOCK_NEAREST,
    output logic O_NETWORK_STANDARD_SELECT,
    output logic O_TDO
);
    localparam int PW = $clog2(PERIOD_CYC + 1);
    localparam int AW = $clog2(AMI_LOS_CYC + 1);
    localparam logic [PW-1:0] PER_LAST = PW'(PERIOD_CYC - 1);
    localparam logic [AW-1:0] AMI_LAST = AW'(AMI_LOS_CYC - 1);

    // the strapped input must exist, and index 15 is kept for no selection
    if (NUM_REFS <= `PRIO_STRAP_CH || NUM_REFS > 15 || GAP_W < 4 || PERIOD_CYC < 8 ||
        AMI_LOS_CYC < 2) begin : g_bad_params
        $error("unsupported parameter values");
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);

    // ==================================================================
    // registers
    ref_mon_pkg::level_t stat_r, input_mode_r, mon_cfg_r, phase_cfg_r;
    ref_mon_pkg::level_t freq_r [NUM_REFS];
    ref_mon_pkg::prio_t prio_r [NUM_REFS];
    ref_mon_pkg::bucket_cfg_s bkt_r [4];
    ref_mon_pkg::level_t acc_r [NUM_REFS];
    logic [NUM_REFS-1:0] alarm_r, alarm_d_r, hit_r, irr, fill, ami_los, dq;
    logic [3:0] sel_r, best;
    logic [1:0] init_cnt_r;
    logic [1:0] strap_sync_r, net_sync_r;
    logic fast_r;

    // ==================================================================
    // axi4-lite slave
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rd_data;
    logic rd_ok, wr_ok;

    assign O_AWREADY = !aw_hold_r;
    assign O_WREADY = !w_hold_r;
    assign O_BVALID = bvalid_r;
    assign O_BRESP = bresp_r;
    assign O_ARREADY = !rvalid_r;
    assign O_RVALID = rvalid_r;
    assign O_RDATA = rdata_r;
    assign O_RRESP = rresp_r;

    wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
    wire do_read = I_ARVALID && !rvalid_r;
    wire [7:0] wr_idx = aw_addr_r[9:2];
    wire [7:0] rd_idx = I_ARADDR[9:2];
    wire wr_lane = do_write && w_strb_r[0];
    wire [7:0] wb = w_data_r[7:0];
    wire [7:0] w_off_freq = wr_idx - `IDX_FREQ_BASE;
    wire [7:0] w_off_prio = wr_idx - `IDX_PRIO_BASE;
    wire [7:0] w_off_bkt = wr_idx - `IDX_BKT_BASE;
    wire [7:0] r_off_freq = rd_idx - `IDX_FREQ_BASE;
    wire [7:0] r_off_prio = rd_idx - `IDX_PRIO_BASE;
    wire [7:0] r_off_bkt = rd_idx - `IDX_BKT_BASE;
    wire [7:0] prio_regs = 8'((NUM_REFS + 1) / 2);
    wire w_is_freq = w_off_freq < 8'(NUM_REFS);
    wire w_is_prio = w_off_prio < prio_regs;
    wire w_is_bkt = w_off_bkt < 8'h10;
    wire w_is_stat = wr_idx == `IDX_INT_STATUS;
    wire w_is_mode = wr_idx == `IDX_INPUT_MODE;
    wire w_is_mon = wr_idx == `IDX_MON_CFG;
    wire w_is_phase = wr_idx == `IDX_PHASE_CFG;
    wire w_is_ro = wr_idx == `IDX_ALARMS || wr_idx == `IDX_AVAIL || wr_idx == `IDX_SELECTED;
    assign wr_ok = w_is_freq || w_is_prio || w_is_bkt || w_is_stat || w_is_mode ||
                   w_is_mon || w_is_phase || w_is_ro;

    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        if (rd_idx == `IDX_INT_STATUS) begin
            rd_data[7:0] = stat_r;
        end else if (rd_idx == `IDX_ALARMS) begin
            rd_data[NUM_REFS-1:0] = alarm_r;
        end else if (rd_idx == `IDX_AVAIL) begin
            rd_data[NUM_REFS-1:0] = O_REF_AVAILABLE;
        end else if (rd_idx == `IDX_SELECTED) begin
            rd_data[3:0] = sel_r;
        end else if (rd_idx == `IDX_INPUT_MODE) begin
            rd_data[7:0] = input_mode_r;
        end else if (rd_idx == `IDX_MON_CFG) begin
            rd_data[7:0] = mon_cfg_r;
        end else if (rd_idx == `IDX_PHASE_CFG) begin
            rd_data[7:0] = phase_cfg_r;
        end else if (r_off_freq < 8'(NUM_REFS)) begin
            rd_data[7:0] = freq_r[r_off_freq[3:0]];
        end else if (r_off_prio < prio_regs) begin
            rd_data[3:0] = prio_r[{r_off_prio[2:0], 1'b0}];
            if ({r_off_prio[2:0], 1'b1} < 4'(NUM_REFS)) begin
                rd_data[7:4] = prio_r[{r_off_prio[2:0], 1'b1}];
            end
        end else if (r_off_bkt < 8'h10) begin
            unique case (r_off_bkt[1:0])
                2'h0: rd_data[7:0] = bkt_r[r_off_bkt[3:2]].size;
                2'h1: rd_data[7:0] = bkt_r[r_off_bkt[3:2]].upper;
                2'h2: rd_data[7:0] = bkt_r[r_off_bkt[3:2]].lower;
                2'h3: rd_data[1:0] = bkt_r[r_off_bkt[3:2]].decay;
            endcase
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else begin
            if (I_AWVALID && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= I_AWADDR;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (I_WVALID && !w_hold_r) begin
                w_hold_r <= 1'b1;
                w_data_r <= I_WDATA;
                w_strb_r <= I_WSTRB;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? 2'h0 : 2'h2;
            end else if (I_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= 2'h0;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_data;
            rresp_r <= rd_ok ? 2'h0 : 2'h2;
        end else if (I_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==================================================================
    // configuration; straps are caught three edges after release
    wire init_cap = init_cnt_r == 2'h2;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            strap_sync_r <= '0;
            net_sync_r <= '0;
            init_cnt_r <= '0;
        end else begin
            strap_sync_r <= {strap_sync_r[0], I_PRIMARY_SECONDARY_STRAP};
            net_sync_r <= {net_sync_r[0], I_NETWORK_STANDARD_PIN};
            if (init_cnt_r != 2'h3) init_cnt_r <= init_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            input_mode_r <= '0;
            mon_cfg_r <= '0;
            phase_cfg_r <= '0;
            for (int i = 0; i < 4; i++) begin
                bkt_r[i] <= '{`RST_BKT_SIZE, `RST_BKT_UPPER, `RST_BKT_LOWER, `RST_BKT_DECAY};
            end
            for (int i = 0; i < NUM_REFS; i++) begin
                freq_r[i] <= '0;
                prio_r[i] <= 4'(i + 2);
            end
            prio_r[`PRIO_STRAP_CH] <= `RST_PRIO_MASTER;
        end else if (init_cap) begin
            prio_r[`PRIO_STRAP_CH] <= strap_sync_r[1] ? `RST_PRIO_MASTER : `RST_PRIO_SLAVE;
            input_mode_r[`NET_STD_BIT] <= net_sync_r[1];
        end else if (wr_lane) begin
            if (w_is_mode) input_mode_r <= wb;
            if (w_is_mon) mon_cfg_r <= wb;
            if (w_is_phase) phase_cfg_r <= wb;
            if (w_is_freq) freq_r[w_off_freq[3:0]] <= wb;
            if (w_is_prio) begin
                prio_r[{w_off_prio[2:0], 1'b0}] <= wb[3:0];
                if ({w_off_prio[2:0], 1'b1} < 4'(NUM_REFS)) begin
                    prio_r[{w_off_prio[2:0], 1'b1}] <= wb[7:4];
                end
            end
            if (w_is_bkt) begin
                unique case (w_off_bkt[1:0])
                    2'h0: bkt_r[w_off_bkt[3:2]].size <= wb;
                    2'h1: bkt_r[w_off_bkt[3:2]].upper <= wb;
                    2'h2: bkt_r[w_off_bkt[3:2]].lower <= wb;
                    2'h3: bkt_r[w_off_bkt[3:2]].decay <= wb[1:0];
                endcase
            end
        end
    end

    // ==================================================================
    // shared period divider
    logic [PW-1:0] div_r;
    logic [2:0] period_r;
    wire tick = div_r == PER_LAST;
    // leak timing per decay setting: every 1, 2, 4 or 8 periods
    wire [3:0] leak_due = {period_r == 3'h0, period_r[1:0] == 2'h0, !period_r[0], 1'b1};

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            div_r <= '0;
            period_r <= '0;
        end else if (tick) begin
            div_r <= '0;
            period_r <= period_r + 3'h1;
        end else begin
            div_r <= div_r + PW'(1);
        end
    end

    // ==================================================================
    // per-input activity monitor and leaky bucket
    // one bucket for every input
    for (genvar c = 0; c < NUM_REFS; c++) begin : g_ch
        logic [2:0] sync_r;
        logic [GAP_W-1:0] gap_r, prev_r;
        ref_mon_pkg::level_t acc_nxt;
        logic alarm_nxt;
        wire rise = sync_r[1] && !sync_r[2];
        wire [1:0] bid = freq_r[c][`FREQ_BKT_LSB +: 2];
        ref_mon_pkg::bucket_cfg_s cfg;
        assign cfg = bkt_r[bid];
        // a gap beyond twice the last period, or a dead input, is irregular
        assign irr[c] = (&gap_r) || (prev_r != '0 && {1'b0, gap_r} > {prev_r, 1'b1});
        assign fill[c] = hit_r[c] || irr[c] || ami_los[c];
        // saturate; fill beats leak; leak step
        assign acc_nxt = (acc_r[c] > cfg.size) ? cfg.size :
                         fill[c] ? ((acc_r[c] < cfg.size) ? acc_r[c] + 8'h01 : acc_r[c]) :
                         (leak_due[cfg.decay] && acc_r[c] != '0) ? acc_r[c] - 8'h01 :
                         acc_r[c];
        // set at upper, clear at lower
        assign alarm_nxt = (acc_nxt >= cfg.upper) ? 1'b1 :
                           (acc_nxt <= cfg.lower) ? 1'b0 : alarm_r[c];

        always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
                sync_r <= '0;
                gap_r <= '0;
                prev_r <= '0;
            end else begin
                sync_r <= {sync_r[1:0], I_REF_IN[c]};
                gap_r <= rise ? '0 : ((&gap_r) ? gap_r : gap_r + GAP_W'(1));
                if (rise) prev_r <= gap_r;
            end
        end

        always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
            if (!I_RESET_N) begin
                hit_r[c] <= 1'b0;
                acc_r[c] <= '0;
                alarm_r[c] <= 1'b0;
            end else if (tick) begin
                hit_r[c] <= 1'b0;
                acc_r[c] <= acc_nxt;
                alarm_r[c] <= alarm_nxt;
            end else begin
                hit_r[c] <= fill[c];
            end
        end

        if (c < `AMI_PORTS) begin : g_ami
            logic [1:0] amp_sync_r;
            logic [AW-1:0] idle_r;
            // idle for 1 ms or low amplitude
            assign ami_los[c] = (idle_r == AMI_LAST) || amp_sync_r[1];
            always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
                if (!I_RESET_N) begin
                    amp_sync_r <= '0;
                    idle_r <= '0;
                end else begin
                    amp_sync_r <= {amp_sync_r[0], I_AMI_LOW_AMP[c]};
                    if (rise) idle_r <= '0;
                    else if (idle_r != AMI_LAST) idle_r <= idle_r + AW'(1);
                end
            end
        end else begin : g_no_ami
            assign ami_los[c] = 1'b0;
        end

        a_bucket_bound: assert property (tick |=> acc_r[c] <= $past(cfg.size))
            else $error("bucket above size");
        a_fill_step: assert property (tick && fill[c] && acc_r[c] < cfg.size |=>
            acc_r[c] == $past(acc_r[c]) + 8'h01)
            else $error("fill missed");
        a_leak_step: assert property (tick && !fill[c] && leak_due[cfg.decay] &&
            acc_r[c] != '0 && acc_r[c] <= cfg.size |=> acc_r[c] == $past(acc_r[c]) - 8'h01)
            else $error("leak missed");
        a_period_only: assert property (!tick |=> $stable(acc_r[c]))
            else $error("bucket moved mid period");
    end

    // ==================================================================
    // qualification and selection
    wire sel_valid = sel_r < 4'(NUM_REFS);
    wire [3:0] sel_i = sel_valid ? sel_r : 4'h0;
    wire sel_extra = I_SEL_PHASE_FAULT || I_SEL_FREQ_FAULT || I_SEL_OUT_OF_RANGE;
    // extra reasons only for the selected input
    assign dq = alarm_r | I_OUT_OF_BAND |
                ((sel_valid && sel_extra) ? (NUM_REFS'(1) << sel_i) : '0);

    always_comb begin
        best = `SEL_NONE;
        for (int i = 0; i < NUM_REFS; i++) begin
            if (prio_r[i] != 4'h0 && !dq[i] &&
                (best == `SEL_NONE || prio_r[i] < prio_r[best])) begin
                best = 4'(i);
            end
        end
    end

    // non-revertive: only a lost selection moves it
    wire sel_lost = !sel_valid || dq[sel_i];
    // gap on the locked input freezes the loop
    wire fast_raw = sel_valid && irr[sel_i];
    wire flag_src = phase_cfg_r[`PHASE_LOST_BIT] ? I_PHASE_LOST : fast_raw;
    wire sel_inval = sel_valid && alarm_r[sel_i] && !alarm_d_r[sel_i];
    wire stat_clr = wr_lane && w_is_stat;

    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sel_r <= `SEL_NONE;
            alarm_d_r <= '0;
            fast_r <= 1'b0;
            stat_r <= '0;
        end else begin
            if (sel_lost) sel_r <= best;
            alarm_d_r <= alarm_r;
            fast_r <= fast_raw;
            // sticky flag, set wins over clear
            stat_r[`MAIN_REF_FAILED_BIT] <= flag_src ||
                (stat_r[`MAIN_REF_FAILED_BIT] && !(stat_clr && wb[`MAIN_REF_FAILED_BIT]));
            stat_r[`SEL_INVALID_BIT] <= sel_inval ||
                (stat_r[`SEL_INVALID_BIT] && !(stat_clr && wb[`SEL_INVALID_BIT]));
        end
    end

    // ==================================================================
    // registered outputs
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_REF_AVAILABLE <= '0;
            O_FREQ_CHECK_EN <= '0;
            O_ACT_ALARM <= '0;
            O_AMI_LOS <= '0;
            O_SELECTED <= `SEL_NONE;
            O_DPLL_HOLDOVER <= 1'b0;
            O_RELOCK_NEAREST <= 1'b0;
            O_NETWORK_STANDARD_SELECT <= 1'b0;
            O_TDO <= 1'b0;
        end else begin
            O_REF_AVAILABLE <= ~(alarm_r | I_OUT_OF_BAND);
            O_FREQ_CHECK_EN <= ~(irr | ami_los);
            O_ACT_ALARM <= alarm_r;
            O_AMI_LOS <= ami_los[1:0];
            O_SELECTED <= sel_r;
            O_DPLL_HOLDOVER <= fast_raw;
            // recovered before alarms: nearest-edge relock
            // a switch to another input is no recovery
            O_RELOCK_NEAREST <= fast_r && !fast_raw && !sel_lost && sel_r == O_SELECTED;
            O_NETWORK_STANDARD_SELECT <= input_mode_r[`NET_STD_BIT];
            // raw status copy on test data out, mask ignored
            O_TDO <= mon_cfg_r[`TDO_FLAG_BIT] ? stat_r[`MAIN_REF_FAILED_BIT] : I_JTAG_TDO;
        end
    end

    // ==================================================================
    // checks
    sequence s_sel_dropped;
        sel_valid && dq[sel_i];
    endsequence
    sequence s_recovered;
        fast_r && !fast_raw && !sel_lost && sel_r == O_SELECTED;
    endsequence

    a_holdover_fast: assert property (fast_raw |=> O_DPLL_HOLDOVER)
        else $error("holdover not forced");
    a_switch_lost: assert property (s_sel_dropped |=> sel_r == $past(best))
        else $error("no switch on lost input");
    a_relock_pulse: assert property (s_recovered |=> O_RELOCK_NEAREST ##1 !O_RELOCK_NEAREST)
        else $error("relock pulse wrong");
    a_flag_sticky: assert property (stat_r[`MAIN_REF_FAILED_BIT] && !stat_clr
        |=> stat_r[`MAIN_REF_FAILED_BIT])
        else $error("fast flag dropped");
    a_tdo_copy: assert property (mon_cfg_r[`TDO_FLAG_BIT] ##1 mon_cfg_r[`TDO_FLAG_BIT]
        |-> O_TDO == $past(stat_r[`MAIN_REF_FAILED_BIT]))
        else $error("tdo not status copy");
    a_unavailable: assert property ((|(alarm_r & ~O_ACT_ALARM)) |=>
        (O_REF_AVAILABLE & $past(alarm_r)) == '0)
        else $error("alarmed input available");
endmodule : ref_clock_quality_monitor

// ==== shared/ref_mon_defines.svh ====
`ifndef REF_MON_DEFINES_SVH
`define REF_MON_DEFINES_SVH

// ==================================================================
// timing
`define CLK_KHZ 125000
`define MON_PERIOD_MS 128
`define AMI_LOS_US 1000

// ==================================================================
// register indices, byte address is four times the index
`define IDX_INT_STATUS 8'h06
`define IDX_ALARMS 8'h08
`define IDX_AVAIL 8'h09
`define IDX_SELECTED 8'h0a
`define IDX_PRIO_BASE 8'h18
`define IDX_FREQ_BASE 8'h20
`define IDX_INPUT_MODE 8'h34
`define IDX_MON_CFG 8'h48
`define IDX_BKT_BASE 8'h50
`define IDX_PHASE_CFG 8'h73

// ==================================================================
// field positions
`define SEL_INVALID_BIT 0
`define MAIN_REF_FAILED_BIT 6
`define NET_STD_BIT 2
`define TDO_FLAG_BIT 6
`define PHASE_LOST_BIT 6
`define FREQ_BKT_LSB 4

// ==================================================================
// reset values
`define RST_BKT_SIZE 8'h08
`define RST_BKT_UPPER 8'h06
`define RST_BKT_LOWER 8'h04
`define RST_BKT_DECAY 2'h1
`define RST_PRIO_MASTER 4'hc
`define RST_PRIO_SLAVE 4'h1
`define PRIO_STRAP_CH 10
`define AMI_PORTS 2
`define SEL_NONE 4'hf

`endif

// ==== shared/ref_mon_pkg.sv ====
package ref_mon_pkg;
    typedef logic [7:0] level_t;
    typedef logic [3:0] prio_t;
    typedef struct packed {
        level_t size;
        level_t upper;
        level_t lower;
        logic [1:0] decay;
    } bucket_cfg_s;
endpackage : ref_mon_pkg

// ==== verification/ref_clock_quality_monitor_tb.sv ====
`timescale 1ns/1ps
// ==================================================================
// bench top
module ref_clock_quality_monitor_tb;
    logic I_REF_CLK = '0, I_RESET_N = '0, I_AWVALID = '0, I_WVALID = '0, I_BREADY = '0;
    logic I_ARVALID = '0, I_RREADY = '0, I_JTAG_TDO = '0, I_PHASE_LOST = '0, a, w, r, b;
    logic I_SEL_PHASE_FAULT = '0, I_SEL_FREQ_FAULT = '0, I_SEL_OUT_OF_RANGE = '0;
    logic I_PRIMARY_SECONDARY_STRAP = 1'h1, I_NETWORK_STANDARD_PIN = 1'h1;
    logic [1:0] I_AMI_LOW_AMP = '0, O_BRESP, O_RRESP, O_AMI_LOS, rresp;
    logic [11:0] I_AWADDR = '0, I_ARADDR = '0;
    logic [31:0] I_WDATA = '0, O_RDATA, rdat;
    logic [3:0] I_WSTRB = 4'h1, O_SELECTED;
    logic [13:0] I_OUT_OF_BAND = '0, alive = '1, O_REF_AVAILABLE, O_FREQ_CHECK_EN, O_ACT_ALARM;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_DPLL_HOLDOVER;
    logic O_RELOCK_NEAREST, O_NETWORK_STANDARD_SELECT, O_TDO;
    logic [7:0] d;
    wire [13:0] I_REF_IN;
    int errors = 0, samples_checked = 0;
    ref_clock_quality_monitor #(.GAP_W(8), .PERIOD_CYC(64), .AMI_LOS_CYC(32)) u_dut (.*);
    ref_source_model u_src (.clk(I_REF_CLK), .alive(alive), .ref_out(I_REF_IN));
    always #4 I_REF_CLK = ~I_REF_CLK;
    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // waits settle at the falling edge, away from the design's updates
    task automatic cyc(int n);
        repeat (n) @(negedge I_REF_CLK);
    endtask : cyc
    task automatic xfer(logic rd);
        @(posedge I_REF_CLK);
        {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} <= {!rd, !rd, !rd, rd, rd};
        for (int n = 0; n < 99; n++) begin
            cyc(1);
            {a, w, r} = {I_AWVALID & O_AWREADY, I_WVALID & O_WREADY, I_ARVALID & O_ARREADY};
            b = (I_BREADY & O_BVALID) | (I_RREADY & O_RVALID);
            {rdat, rresp} = {O_RDATA, rd ? O_RRESP : O_BRESP};
            @(posedge I_REF_CLK);
            if (a) I_AWVALID <= 1'h0;
            if (w) I_WVALID <= 1'h0;
            if (r) I_ARVALID <= 1'h0;
            if (b) {I_BREADY, I_RREADY} <= 2'h0;
            if (b) return;
        end
        errors++;
        give_verdict();
    endtask : xfer
    task automatic wr(logic [7:0] ix, logic [7:0] v);
        {I_AWADDR, I_WDATA} <= {2'h0, ix, 2'h0, 24'h0, v};
        xfer(1'h0);
    endtask : wr
    task automatic rd(logic [7:0] ix, logic [7:0] e, logic [1:0] er = 2'h0);
        I_ARADDR <= {2'h0, ix, 2'h0};
        xfer(1'h1);
        chk("rdata", {24'h0, e}, rdat);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd
    task automatic till(logic v, int lim);
        for (int n = 0; n < lim && O_ACT_ALARM[0] !== v; n++) cyc(1);
        chk("alarm", {31'h0, v}, {31'h0, O_ACT_ALARM[0]});
    endtask : till
    function automatic logic [7:0] bkt(int f);
        return f == 0 ? 8'h08 : f == 1 ? 8'h06 : f == 2 ? 8'h04 : 8'h01;
    endfunction : bkt
    initial begin
        void'($urandom(48));
        repeat (10) @(posedge I_REF_CLK);
        I_RESET_N <= 1'h1;
        cyc(5);
        rd(8'h1d, 8'hdc);
        rd(8'h1e, 8'hfe);
        for (int f = 0; f < 4; f++) rd(8'h50 + f[7:0], bkt(f));
        rd(8'h34, 8'h04);
        rd(8'h3f, 8'h00, 2'h2);
        $display("defaults done");
        repeat (4) begin
            @(posedge I_REF_CLK);
            d = 8'($urandom);
            I_JTAG_TDO <= d[7];
            I_OUT_OF_BAND[5] <= d[0];
            I_AMI_LOW_AMP[1] <= d[1];
            I_WSTRB <= 4'hf;
            wr(8'h34, d);
            cyc(2);
            chk("netstd", {31'h0, d[2]}, {31'h0, O_NETWORK_STANDARD_SELECT});
            chk("tdo", {31'h0, d[7]}, {31'h0, O_TDO});
            chk("avail", {31'h0, !d[0]}, {31'h0, O_REF_AVAILABLE[5]});
            chk("amilos", {31'h0, d[1]}, {31'h0, O_AMI_LOS[1]});
        end
        $display("random done");
        I_AMI_LOW_AMP <= 2'h0;
        wr(8'h48, 8'h40);
        // input 3 on bucket config 3 with set threshold 2
        wr(8'h5d, 8'h02);
        wr(8'h23, 8'h30);
        alive <= 14'h3ff6;
        cyc(40);
        chk("holdover", 32'h1, {31'h0, O_DPLL_HOLDOVER});
        chk("tdo", 32'h1, {31'h0, O_TDO});
        chk("freqchk", 32'h0, {31'h0, O_FREQ_CHECK_EN[0]});
        chk("amilos", 32'h1, {30'h0, O_AMI_LOS});
        rd(8'h06, 8'h40);
        cyc(150);
        chk("alarm3", 32'h1, {31'h0, O_ACT_ALARM[3]});
        till(1'h0, 1);
        till(1'h1, 1000);
        cyc(3);
        chk("sel", 32'h1, {28'h0, O_SELECTED});
        chk("avail", 32'h0, {31'h0, O_REF_AVAILABLE[0]});
        rd(8'h06, 8'h41);
        // short dropout on the selected input, back before any alarm
        alive[1] <= 1'h0;
        cyc(40);
        alive[1] <= 1'h1;
        for (int n = 0; n < 40 && O_RELOCK_NEAREST !== 1'h1; n++) cyc(1);
        chk("relock", 32'h1, {31'h0, O_RELOCK_NEAREST});
        cyc(1);
        chk("relock", 32'h0, {31'h0, O_RELOCK_NEAREST});
        // the fault follows the selection, so it stands one cycle only
        @(posedge I_REF_CLK);
        I_SEL_FREQ_FAULT <= 1'h1;
        @(posedge I_REF_CLK);
        I_SEL_FREQ_FAULT <= 1'h0;
        cyc(3);
        chk("sel", 32'h2, {28'h0, O_SELECTED});
        cyc(300);
        @(posedge I_REF_CLK);
        alive[0] <= 1'h1;
        wr(8'h06, 8'h41);
        rd(8'h06, 8'h00);
        chk("tdo", 32'h0, {31'h0, O_TDO});
        wr(8'h73, 8'h40);
        I_PHASE_LOST <= 1'h1;
        rd(8'h06, 8'h40);
        cyc(270);
        till(1'h1, 1);
        till(1'h0, 1000);
        $display("bucket done");
        give_verdict();
    end
endmodule : ref_clock_quality_monitor_tb

// ==== verification/ref_source_model.sv ====
`timescale 1ns/1ps
// ==================================================================
// reference sources
module ref_source_model (
    input wire logic clk,
    input wire logic [13:0] alive,
    output logic [13:0] ref_out
);
    logic [1:0] cnt_r = '0;
    initial ref_out = '0;
    // a dead source holds its level: no edges at all
    always @(posedge clk) begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == 2'h0) ref_out <= ref_out ^ alive;
    end
endmodule : ref_source_model
